// ---- bench/idr_host_model.sv ----
// behavioural carrier-side host controller issuing byte bus cycles
`timescale 1ns/1ps
`default_nettype none
module idr_host_model (
	input  wire logic       mclk_i,
	input  wire logic       ack_n_i,
	input  wire logic [7:0] rdata_i,
	output logic            idsel_n_o,
	output logic            iosel_n_o,
	output logic            intsel_n_o,
	output logic            rw_n_o,
	output logic [5:0]      addr_o,
	output logic [7:0]      wdata_o
);
	// idle bus at time zero
	initial begin
		{idsel_n_o, iosel_n_o, intsel_n_o, rw_n_o} = 4'hF;
		addr_o  = 6'h00;
		wdata_o = 8'h00;
	end
	// one cycle: sp 0 id, 1 io, 2 int ack; held until ack is sampled
	task automatic cyc(input logic [1:0] sp, input logic rd,
		input logic [6:0] off, input logic [7:0] wd,
		output logic [7:0] rdat, output int waits);
		int n;
		n = 0;
		@(posedge mclk_i);
		// separate select for the table space
		idsel_n_o  <= (sp != 2'd0);
		iosel_n_o  <= (sp != 2'd1);
		intsel_n_o <= (sp != 2'd2);
		rw_n_o     <= rd;
		// byte offset mapped to word lines
		addr_o     <= off[6:1];
		wdata_o    <= wd;
		do begin
			@(posedge mclk_i);
			n++;
		end while (ack_n_i !== 1'b0 && n < 20);
		rdat  = rdata_i;
		waits = n - 2;
		{idsel_n_o, iosel_n_o, intsel_n_o} <= 3'h7;
		// released data lines toggle so stale values never look valid
		wdata_o <= ~wd;
	endtask
endmodule // idr_host_model
`default_nettype wire

// ---- bench/tb_module_id_space_responder.sv ----
// self-checking bench for the identification space responder
`timescale 1ns/1ps
`default_nettype none
module tb_module_id_space_responder;
	import idr_pkg::*;
	localparam logic [7:0] T_MAKER = 8'h6B; // arbitrary value
	localparam logic [7:0] T_MODEL = 8'h2D; // arbitrary value
	localparam logic [7:0] T_REV   = 8'h07; // arbitrary value
	logic       mclk_i = 1'b0;
	logic       arst_n_i = 1'b0;
	logic       idsel_n, iosel_n, intsel_n, rw_n, ack_n, oe_n, irq_n;
	logic [5:0] addr;
	logic [7:0] wdata, rdata, rd;
	logic [3:0] borrow = 4'h0;
	logic [3:0] match = 4'h0;
	int         n_mismatch = 0;
	int         checks = 0;
	int         w;
	always #4 mclk_i = ~mclk_i;
	idr_host_model u_host (.mclk_i(mclk_i), .ack_n_i(ack_n), .rdata_i(rdata),
		.idsel_n_o(idsel_n), .iosel_n_o(iosel_n), .intsel_n_o(intsel_n),
		.rw_n_o(rw_n), .addr_o(addr), .wdata_o(wdata));
	idr_responder #(.MAKER_CODE(T_MAKER), .MODEL_CODE(T_MODEL),
		.REV_LEVEL(T_REV)) u_dut (.mclk_i(mclk_i), .arst_n_i(arst_n_i),
		.idsel_n_i(idsel_n), .iosel_n_i(iosel_n), .intsel_n_i(intsel_n),
		.rw_n_i(rw_n), .addr_i(addr), .data_i(wdata), .data_o(rdata),
		.data_oe_n_o(oe_n), .ack_n_o(ack_n), .intreq0_n_o(irq_n),
		.borrow_i(borrow), .match_i(match));
	////////////////////////////////////////////////////////////////////////
	// compare and count
	task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] g);
		checks++;
		if (g !== e) begin
			n_mismatch++;
			$display("ERROR %s expected %h seen %h", nm, e, g);
		end
	endtask
	task automatic end_of_test;
		$display("mismatches %0d checks %0d", n_mismatch, checks);
		if (n_mismatch == 0 && checks > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask
	////////////////////////////////////////////////////////////////////////
	// every standard offset plus both user bounds, zero wait
	task automatic t_table;
		logic [6:0] o [14] = '{7'h01, 7'h03, 7'h05, 7'h07, 7'h09, 7'h0B, 7'h0D,
			7'h0F, 7'h11, 7'h13, 7'h15, 7'h17, 7'h19, 7'h3F};
		logic [7:0] v [14] = '{8'h49, 8'h50, 8'h41, 8'h43, T_MAKER, T_MODEL,
			T_REV, 8'h00, 8'h01, 8'h00, 8'h0C, 8'hE0, 8'h00, 8'h00};
		for (int i = 0; i < 14; i++) begin
			u_host.cyc(2'd0, 1'b1, o[i], 8'h00, rd, w);
			chk("table byte", v[i], rd);
			chk("id wait", 8'h00, 8'(w));
			chk("table oe", 8'h00, 8'(oe_n));
		end
		$display("test table done");
	endtask
	// table writes acked with no effect
	task automatic t_id_write;
		u_host.cyc(2'd0, 1'b0, 7'h11, 8'hFF, rd, w);
		chk("id write wait", 8'h00, 8'(w));
		chk("id write oe", 8'h01, 8'(oe_n));
		u_host.cyc(2'd0, 1'b1, 7'h11, 8'h00, rd, w);
		chk("id after write", 8'h01, rd);
		$display("test id write done");
	endtask
	// data space: exactly one wait on reads and writes
	task automatic t_data;
		u_host.cyc(2'd1, 1'b0, 7'h01, 8'hA8, rd, w);
		chk("io write wait", 8'h01, 8'(w));
		u_host.cyc(2'd1, 1'b1, 7'h01, 8'h00, rd, w);
		chk("vector base", 8'hA8, rd);
		chk("io read wait", 8'h01, 8'(w));
		u_host.cyc(2'd1, 1'b1, 7'h07, 8'h00, rd, w);
		chk("unmapped", 8'h00, rd);
		$display("test data done");
	endtask
	// hold an event line pattern for two cycles
	task automatic pulse(input logic [3:0] b, input logic [3:0] m);
		@(posedge mclk_i);
		borrow <= b;
		match  <= m;
		repeat (2) @(posedge mclk_i);
		borrow <= 4'h0;
		match  <= 4'h0;
		repeat (6) @(posedge mclk_i);
	endtask
	// source select, pending, vector with channel number
	task automatic t_irq;
		u_host.cyc(2'd1, 1'b0, 7'h03, 8'h64, rd, w);
		pulse(4'h4, 4'h2);
		chk("unselected source", 8'h01, 8'(irq_n));
		pulse(4'h2, 4'h4);
		chk("irq low", 8'h00, 8'(irq_n));
		u_host.cyc(2'd1, 1'b1, 7'h05, 8'h00, rd, w);
		chk("pending", 8'h06, rd);
		u_host.cyc(2'd2, 1'b1, 7'h00, 8'h00, rd, w);
		chk("vector ch1", 8'hA9, rd);
		u_host.cyc(2'd2, 1'b1, 7'h00, 8'h00, rd, w);
		chk("vector ch2", 8'hAA, rd);
		@(posedge mclk_i);
		chk("irq released", 8'h01, 8'(irq_n));
		$display("test irq done");
	endtask
	////////////////////////////////////////////////////////////////////////
	// main sequence
	initial begin
		repeat (20) @(posedge mclk_i);
		arst_n_i <= 1'b1;
		t_table();
		t_id_write();
		t_data();
		t_irq();
		end_of_test();
	end
	// watchdog fails the run if it is still going after 4000 clock cycles
	initial begin
		#(8 * 4000);
		n_mismatch++;
		end_of_test();
	end
endmodule // tb_module_id_space_responder
`default_nettype wire

// ---- hw/idr_pkg.sv ----
// constants and types for the identification space responder
package idr_pkg;

	// identification table geometry and byte offsets
	localparam int         ID_WORDS      = 32;
	localparam logic [6:0] OFF_SIG0      = 7'h01;
	localparam logic [6:0] OFF_SIG1      = 7'h03;
	localparam logic [6:0] OFF_SIG2      = 7'h05;
	localparam logic [6:0] OFF_SIG3      = 7'h07;
	localparam logic [6:0] OFF_MAKER     = 7'h09;
	localparam logic [6:0] OFF_MODEL     = 7'h0B;
	localparam logic [6:0] OFF_REV       = 7'h0D;
	localparam logic [6:0] OFF_RSVD      = 7'h0F;
	localparam logic [6:0] OFF_DRV_LO    = 7'h11;
	localparam logic [6:0] OFF_DRV_HI    = 7'h13;
	localparam logic [6:0] OFF_COUNT     = 7'h15;
	localparam logic [6:0] OFF_CSUM      = 7'h17;
	localparam logic [6:0] OFF_USER_LO   = 7'h19;
	localparam logic [6:0] OFF_USER_HI   = 7'h3F;

	// fixed table contents
	localparam logic [7:0] VAL_SIG0      = 8'h49;
	localparam logic [7:0] VAL_SIG1      = 8'h50;
	localparam logic [7:0] VAL_SIG2      = 8'h41;
	localparam logic [7:0] VAL_SIG3      = 8'h43;
	localparam logic [7:0] VAL_RSVD      = 8'h00;
	localparam logic [7:0] VAL_DRV_LO    = 8'h01;
	localparam logic [7:0] VAL_DRV_HI    = 8'h00;
	localparam logic [7:0] VAL_COUNT     = 8'h0C;
	localparam logic [7:0] VAL_CSUM      = 8'hE0;
	localparam logic [7:0] VAL_USER      = 8'h00;

	// data space byte offsets and reset values
	localparam logic [6:0] OFF_VEC_BASE  = 7'h01;
	localparam logic [6:0] OFF_IRQ_CTRL  = 7'h03;
	localparam logic [6:0] OFF_IRQ_STAT  = 7'h05;
	localparam logic [5:0] RST_VEC_BASE  = 6'h00;
	localparam logic [3:0] RST_SRC_SEL   = 4'h0;
	localparam logic [3:0] RST_IRQ_EN    = 4'h0;

	// bus cycle sequencer
	typedef enum logic [1:0] {
		ST_IDLE = 2'b00,
		ST_WAIT = 2'b01,
		ST_ACK  = 2'b10
	} idr_state_type;

endpackage

// ---- hw/idr_responder.sv ----
// identification space and host port of a four channel counter module
// Functional notes
// - a read-only table of at least 32 byte locations identifies the module.
// - the table carries the module's manufacturing revision level.
// - standard data sits on odd offsets 01..17, and 19..3F is user space.
// - a driver identifier reads 01 at offset 11 and 00 at offset 13.
// - the table is fixed, with 0C at offset 15 and E0 at offset 17.
// - the table is built in logic and starts with bytes 49 50 41 43.
// - table reads take no wait state and data space cycles take exactly one.
// - the acknowledge vector is six programmed bits plus a two bit channel.
// - each channel interrupts on borrow or on compare match, by software.
`timescale 1ns/1ps
`default_nettype none

module idr_responder
	import idr_pkg::*;
#(
	parameter logic [7:0] MAKER_CODE = 8'h5A, // arbitrary value
	parameter logic [7:0] MODEL_CODE = 8'h3C, // arbitrary value
	parameter logic [7:0] REV_LEVEL  = 8'h01, // arbitrary value
	parameter int         CHANNELS   = 4
) (
	input  wire logic                mclk_i,
	input  wire logic                arst_n_i,
	input  wire logic                idsel_n_i,
	input  wire logic                iosel_n_i,
	input  wire logic                intsel_n_i,
	input  wire logic                rw_n_i,
	input  wire logic [5:0]          addr_i,
	input  wire logic [7:0]          data_i,
	output logic      [7:0]          data_o,
	output logic                     data_oe_n_o,
	output logic                     ack_n_o,
	output logic                     intreq0_n_o,
	input  wire logic [CHANNELS-1:0] borrow_i,
	input  wire logic [CHANNELS-1:0] match_i
);

	////////////////////////////////////////////////////////////////////////
	// declarations

	idr_state_type         state;
	logic                  cyc_read;
	logic [5:0]            vec_base;
	logic [CHANNELS-1:0]   src_sel;
	logic [CHANNELS-1:0]   irq_en;
	logic [CHANNELS-1:0]   pend;
	logic [CHANNELS-1:0]   bor_s1, bor_s2, bor_s3;
	logic [CHANNELS-1:0]   mat_s1, mat_s2, mat_s3;
	logic [CHANNELS-1:0]   event_hit;
	logic [CHANNELS-1:0]   ack_clear;
	logic [1:0]            irq_chan;
	logic [6:0]            byte_addr;
	logic                  start_id;
	logic                  start_io;
	logic                  start_int;
	logic [7:0]            next_data;

	// the host bus runs on mclk_i, so its strobes need no synchroniser
	assign byte_addr = {addr_i, 1'b1};
	assign start_id  = (state == ST_IDLE) && !idsel_n_i;
	assign start_io  = (state == ST_IDLE) && idsel_n_i && !iosel_n_i;
	assign start_int = (state == ST_IDLE) && idsel_n_i && iosel_n_i
		&& !intsel_n_i;

	////////////////////////////////////////////////////////////////////////
	// identification table

	function automatic logic [7:0] id_lookup(input logic [6:0] b);
		case (b)
			OFF_SIG0:   return VAL_SIG0;
			OFF_SIG1:   return VAL_SIG1;
			OFF_SIG2:   return VAL_SIG2;
			OFF_SIG3:   return VAL_SIG3;
			OFF_MAKER:  return MAKER_CODE;
			OFF_MODEL:  return MODEL_CODE;
			OFF_REV:    return REV_LEVEL;
			OFF_RSVD:   return VAL_RSVD;
			OFF_DRV_LO: return VAL_DRV_LO;
			OFF_DRV_HI: return VAL_DRV_HI;
			OFF_COUNT:  return VAL_COUNT;
			OFF_CSUM:   return VAL_CSUM;
			default:    return VAL_USER; // user area reads as zero
		endcase
	endfunction

	////////////////////////////////////////////////////////////////////////
	// interrupt channel selection

	// lowest pending channel wins; with none pending channel 0 is reported
	always_comb begin
		irq_chan = 2'b00;
		for (int i = CHANNELS - 1; i >= 0; i--) begin
			if (pend[i]) begin
				irq_chan = 2'(i);
			end
		end
	end

	// read data for a table or vector cycle just starting, or a data space cycle in its wait state
	always_comb begin
		next_data = data_o;
		if (start_id) begin
			next_data = id_lookup(byte_addr);
		end else if (start_int) begin
			next_data = {vec_base, irq_chan};
		end else if (state == ST_WAIT) begin
			case (byte_addr)
				OFF_VEC_BASE: next_data = {vec_base, 2'b00};
				OFF_IRQ_CTRL: next_data = {irq_en, src_sel};
				OFF_IRQ_STAT: next_data = {4'h0, pend};
				default:      next_data = 8'h00;
			endcase
		end
	end

	////////////////////////////////////////////////////////////////////////
	// bus cycle sequencer

	always_ff @(posedge mclk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			state <= ST_IDLE;
		end else begin
			case (state)
				ST_IDLE: begin
					if (start_io) begin
						state <= ST_WAIT;
					end else if (start_id || start_int) begin
						state <= ST_ACK;
					end
				end
				ST_WAIT: state <= ST_ACK;
				ST_ACK:  state <= ST_IDLE;
				default: state <= ST_IDLE;
			endcase
		end
	end

	// direction of the running cycle, latched at its start
	always_ff @(posedge mclk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			cyc_read <= 1'b0;
		end else if (start_id || start_io || start_int) begin
			// a table write with intsel also low must not turn the bus
			cyc_read <= rw_n_i || start_int;
		end
	end

	// read data register; stays put between cycles
	always_ff @(posedge mclk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			data_o <= 8'h00;
		end else begin
			data_o <= next_data;
		end
	end

	// handshake outputs from the state register
	assign ack_n_o     = (state != ST_ACK);
	assign data_oe_n_o = !((state == ST_ACK) && cyc_read);

	////////////////////////////////////////////////////////////////////////
	// data space registers

	// table writes only complete the cycle
	// writes land at the end of the wait state while the host holds data
	always_ff @(posedge mclk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			vec_base <= RST_VEC_BASE;
			src_sel  <= RST_SRC_SEL;
			irq_en   <= RST_IRQ_EN;
		end else if ((state == ST_WAIT) && !cyc_read) begin
			if (byte_addr == OFF_VEC_BASE) begin
				vec_base <= data_i[7:2];
			end
			if (byte_addr == OFF_IRQ_CTRL) begin
				src_sel <= data_i[3:0];
				irq_en  <= data_i[7:4];
			end
		end
	end

	////////////////////////////////////////////////////////////////////////
	// counter events

	// counter outputs are asynchronous to mclk_i; third stage finds edges
	always_ff @(posedge mclk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			bor_s1 <= '0;
			bor_s2 <= '0;
			bor_s3 <= '0;
			mat_s1 <= '0;
			mat_s2 <= '0;
			mat_s3 <= '0;
		end else begin
			bor_s1 <= borrow_i;
			bor_s2 <= bor_s1;
			bor_s3 <= bor_s2;
			mat_s1 <= match_i;
			mat_s2 <= mat_s1;
			mat_s3 <= mat_s2;
		end
	end

	for (genvar g = 0; g < CHANNELS; g++) begin : g_chan
		assign event_hit[g] = src_sel[g] ? (mat_s2[g] && !mat_s3[g])
			: (bor_s2[g] && !bor_s3[g]);
		assign ack_clear[g] = start_int && (irq_chan == 2'(g));

		a_src_event: assert property (@(posedge mclk_i)
			disable iff (!arst_n_i)
			(src_sel[g] && mat_s2[g] && !mat_s3[g])
			|| (!src_sel[g] && bor_s2[g] && !bor_s3[g])
			|=> pend[g])
			else $error("selected event lost");

		a_src_masked: assert property (@(posedge mclk_i)
			disable iff (!arst_n_i)
			!pend[g] && (src_sel[g] ? !(mat_s2[g] && !mat_s3[g])
			: !(bor_s2[g] && !bor_s3[g])) |=> !pend[g])
			else $error("unselected event raised a flag");
	end

	// pending flags; a new event beats the acknowledge that clears it
	always_ff @(posedge mclk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			pend <= '0;
		end else begin
			pend <= event_hit | (pend & ~ack_clear);
		end
	end

	assign intreq0_n_o = !(|(pend & irq_en));

	////////////////////////////////////////////////////////////////////////
	// checks

	sequence s_id_read(logic [6:0] b);
		start_id && rw_n_i && (byte_addr == b);
	endsequence

	sequence s_ack_now;
		!ack_n_o && !data_oe_n_o;
	endsequence

	a_id_zero_wait: assert property (@(posedge mclk_i) disable iff (!arst_n_i)
		start_id |=> !ack_n_o ##1 ack_n_o)
		else $error("table read not acked in one cycle");

	a_io_one_wait: assert property (@(posedge mclk_i) disable iff (!arst_n_i)
		start_io |=> ack_n_o ##1 !ack_n_o ##1 ack_n_o)
		else $error("data cycle wait state wrong");

	a_sig_bytes: assert property (@(posedge mclk_i) disable iff (!arst_n_i)
		s_id_read(OFF_SIG0) |=> s_ack_now and (data_o == VAL_SIG0))
		else $error("first signature byte wrong");

	a_drv_ident: assert property (@(posedge mclk_i) disable iff (!arst_n_i)
		s_id_read(OFF_DRV_LO) |=> s_ack_now and (data_o == VAL_DRV_LO))
		else $error("driver identifier low byte wrong");

	a_csum_byte: assert property (@(posedge mclk_i) disable iff (!arst_n_i)
		s_id_read(OFF_CSUM) |=> (data_o == VAL_CSUM))
		else $error("checksum byte wrong");

	a_rev_byte: assert property (@(posedge mclk_i) disable iff (!arst_n_i)
		s_id_read(OFF_REV) |=> (data_o == REV_LEVEL))
		else $error("revision byte wrong");

	a_user_zero: assert property (@(posedge mclk_i) disable iff (!arst_n_i)
		start_id && rw_n_i && (byte_addr >= OFF_USER_LO)
		&& (byte_addr <= OFF_USER_HI) |=> (data_o == VAL_USER))
		else $error("user area not zero");

	a_id_write: assert property (@(posedge mclk_i) disable iff (!arst_n_i)
		start_id && !rw_n_i |=> !ack_n_o && data_oe_n_o
		&& $stable(vec_base) && $stable(src_sel))
		else $error("table write misbehaved");

	a_vec_layout: assert property (@(posedge mclk_i) disable iff (!arst_n_i)
		start_int && (pend != '0) |=> s_ack_now
		and (data_o[7:2] == vec_base)
		and (data_o[1:0] == $past(irq_chan))
		and $past(pend[irq_chan]))
		else $error("vector layout wrong");

endmodule // idr_responder

`default_nettype wire
